// File: vio_ctrl.sv
// How it works
// - fixed priority, line 7 highest, 0 lowest
// - rotating circle, last serviced ranks lowest
// - rotating mode blocks all while servicing
// - common vector uses level seven slot
// - poll mode kills output, vectoring, fencing
// - disarmed acts as everything masked
// - active-low request and output, polarity zero
// - status low bits, inverted winning level
// - status top bit, unmasked request pending
// - status bit three mirrors arm state
// - status bits show poll and rotate
// - control read returns status directly
// - acknowledge clears request, sets in-service
// - auto-clear drops in-service within acknowledge
// - fixed fence passes only higher levels
// - per-level auto-clear, no fence raised
// - control writes are commands
// - data read selected by two bits
// - filtered requests latched until cleared
// - acknowledge drives winning level vector
// - zero command resets options and latches, not rotation anchor or write target
`timescale 1ns/1ps
`default_nettype none
module vio_ctrl
   import vio_pkg::*;
#(
   parameter int LEVELS = 8  // bus request lines
) (
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic [LEVELS-1:0] bus_req_n,   // active-low request lines
   input  wire logic              port_rd,     // one-cycle read strobe
   input  wire logic              port_wr,     // one-cycle write strobe
   input  wire logic              port_ctrl,   // 1 control port, 0 data port
   input  wire logic [7:0]        port_wdata,  // write data
   input  wire logic              inta,        // one-cycle acknowledge strobe
   output logic [7:0]             port_rdata,  // read or vector data
   output logic                   port_rvalid, // data valid, one cycle
   output logic                   group_int_n  // active-low group interrupt
);
   // ==========================================================================
   // state
   // option, request, mask, in-service and auto-clear latches also return
   // to their reset values on the zero command; the rest keep their contents
   logic [7:0]  opt_q;        // option_control_reg
   logic [7:0]  req_q;        // request_latch
   logic [7:0]  mask_q;       // level_mask_latch
   logic [7:0]  svc_q;        // in_service_latch
   logic [7:0]  aclr_q;       // auto_clear_select
   logic [7:0]  vec_q [8];    // vector memory, indexed by level
   logic [2:0]  last_q;       // level serviced most recently
   vio_wtgt_t   wtgt_q;       // target of the next data write
   logic [2:0]  vsel_q;       // vector slot chosen for writing
   logic [7:0]  caught;       // filtered request pulses

   // ==========================================================================
   // request filters, one per line
   // each filter passes a single catch pulse, so a line held low after its
   // acknowledge does not request again until it has gone high
   genvar gi;
   generate
      for (gi = 0; gi < LEVELS; gi++) begin : g_flt
         vio_req_filter u_flt (
            .sys_clk (sys_clk),
            .resetn  (resetn),
            .req_n   (bus_req_n[gi]),
            .caught  (caught[gi])
         );
      end
   endgenerate

   // ==========================================================================
   // priority resolution
   logic [7:0] live;       // armed and unmasked requests
   logic       any_live;   // at least one live request
   logic [2:0] win;        // winning level
   logic [2:0] top_svc;    // highest set in-service level
   logic       allow;      // fence or rotation permits the winner
   logic [2:0] rot;        // level under inspection
   logic       rot_hit;    // rotation scan has a winner

   // live requests feed the status code, the acknowledge and the group output,
   // so the arm bit gates them once here rather than at each consumer; a
   // disarmed controller therefore also hides its pending code
   always_comb begin
      // defaults keep every path assigned; win 0 is harmless when nothing is live
      live     = req_q & ~mask_q & {8{opt_q[OPT_ARM]}};
      any_live = |live;
      win      = 3'h0;
      rot_hit  = 1'b0;
      top_svc  = 3'h0;
      rot      = 3'h0;
      if (opt_q[OPT_ROTATE]) begin
         // walk downward from the level just below the last serviced one
         for (int k = 1; k <= 8; k++) begin
            rot = last_q - 3'(k);
            if (!rot_hit && live[rot]) begin
               win     = rot;
               rot_hit = 1'b1;
            end
         end
      end else begin
         // ascending scan, so the last live level found, the highest, wins
         for (int k = 0; k < 8; k++) begin
            if (live[k]) begin
               win = 3'(k);
            end
         end
      end
      // highest in-service level marks the current fence height
      for (int k = 0; k < 8; k++) begin
         if (svc_q[k]) begin
            top_svc = 3'(k);
         end
      end
      // rotation never nests; fixed mode only lets a higher level past
      if (opt_q[OPT_ROTATE]) begin
         allow = (svc_q == ZERO8);
      end else begin
         allow = (svc_q == ZERO8) || (win > top_svc);
      end
   end

   // ==========================================================================
   // command decode
   logic       cmd_wr;   // control-port write
   logic       dat_wr;   // data-port write
   logic       ack;      // acknowledge taken
   logic [2:0] cbit;     // bit field of the command
   logic [7:0] cone;     // one-hot of that bit
   logic [7:0] ack_one;  // one-hot of the acknowledged level

   assign cmd_wr  = port_wr && port_ctrl;
   assign dat_wr  = port_wr && !port_ctrl;
   // polled mode has no acknowledge path at all; a request held back by the
   // fence or by a rotation in service is kept from the processor, so its
   // acknowledge is ignored as well and neither latch moves
   // this keeps the vector bus quiet when software acknowledges blindly
   assign ack     = inta && !opt_q[OPT_POLL] && any_live && allow;
   assign cbit    = port_wdata[2:0];
   assign cone    = 8'h01 << cbit;
   assign ack_one = 8'h01 << win;

   // option register; polarity bits are forced to zero
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         opt_q <= OPT_RESET;
      end else if (cmd_wr) begin
         if (port_wdata == ZERO8) begin
            opt_q <= OPT_RESET;
         end else if (port_wdata[7:5] == 3'b100) begin
            // rotation, common vector and poll load together; the polarity
            // fields are accepted but pinned, since this build only has
            // active-low pins
            opt_q[2:0] <= port_wdata[2:0];
            opt_q[4:3] <= 2'b00;
         end else if (port_wdata[7:4] == 4'b1010) begin
            // read preselect, then the arm field; code 11 is illegal and ignored
            opt_q[6:5] <= port_wdata[3:2];
            if (port_wdata[1:0] == 2'b01) begin
               opt_q[OPT_ARM] <= 1'b1;
            end else if (port_wdata[1:0] == 2'b10) begin
               opt_q[OPT_ARM] <= 1'b0;
            end
         end
      end
   end

   // request latch; a fresh catch beats a clear in the same cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         req_q <= ZERO8;
      end else begin
         logic [7:0] r;
         r = req_q;
         if (cmd_wr) begin
            // clear-all, clear-one, set-all and set-one; set-all is a test aid
            case (port_wdata[7:3])
               5'b00000: r = (port_wdata == ZERO8) ? ZERO8 : r;
               5'b00010: r = ZERO8;
               5'b00011: r = r & ~cone;
               5'b01000: r = ZERO8;
               5'b01001: r = r & ~cone;
               5'b01010: r = 8'hFF;
               5'b01011: r = r | cone;
               default:  r = r;
            endcase
         end
         if (ack) begin
            // the acknowledged level leaves the latch at the same edge
            r = r & ~ack_one;
         end
         req_q <= r | caught;
      end
   end

   // mask latch, from commands and preselected data writes
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mask_q <= MASK_RESET;
      end else if (cmd_wr) begin
         // the combined clear codes clear the same request latch bits as well
         case (port_wdata[7:3])
            5'b00000: mask_q <= (port_wdata == ZERO8) ? MASK_RESET : mask_q;
            5'b00010: mask_q <= ZERO8;
            5'b00011: mask_q <= mask_q & ~cone;
            5'b00100: mask_q <= ZERO8;
            5'b00101: mask_q <= mask_q & ~cone;
            5'b00110: mask_q <= MASK_RESET;
            5'b00111: mask_q <= mask_q | cone;
            default:  mask_q <= mask_q;
         endcase
      end else if (dat_wr && wtgt_q == VIO_WT_MASK) begin
         // a parallel load only lands when the mask is the write target
         mask_q <= port_wdata;
      end
   end

   // auto-clear select, one bit per level
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aclr_q <= ZERO8;
      end else if (cmd_wr && port_wdata == ZERO8) begin
         // only the zero command clears it; there is no per-bit command
         aclr_q <= ZERO8;
      end else if (dat_wr && wtgt_q == VIO_WT_ACLR) begin
         aclr_q <= port_wdata;
      end
   end

   // in-service latch; an auto-clear level never sets, so no fence appears
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         svc_q <= ZERO8;
      end else begin
         logic [7:0] s;
         logic [7:0] hi_one;
         s      = svc_q;
         hi_one = 8'h01 << top_svc;
         // clear-all, clear-highest and clear-one; clear-highest can pick the
         // wrong level when auto-clear levels are mixed with fenced ones
         if (cmd_wr) begin
            if (port_wdata == ZERO8 || port_wdata[7:3] == 5'b01110) begin
               s = ZERO8;
            end else if (port_wdata[7:4] == 4'b0110) begin
               s = s & ~hi_one;
            end else if (port_wdata[7:3] == 5'b01111) begin
               s = s & ~cone;
            end
         end
         // auto-clear levels never set, which is how they avoid a fence
         if (ack && !aclr_q[win]) begin
            s = s | ack_one;
         end
         svc_q <= s;
      end
   end

   // rotation anchor and data write target
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         last_q <= 3'h0;
         wtgt_q <= VIO_WT_MASK;
         vsel_q <= 3'h0;
      end else begin
         // the anchor moves only on a real acknowledge, never on a poll
         if (ack) begin
            last_q <= win;
         end
         // the target persists across writes and is not touched by the zero
         // command, so software reselects it after a reset command
         if (cmd_wr) begin
            if (port_wdata[7:4] == 4'b1011) begin
               wtgt_q <= VIO_WT_MASK;
            end else if (port_wdata[7:4] == 4'b1100) begin
               wtgt_q <= VIO_WT_ACLR;
            end else if (port_wdata[7:3] == 5'b11100) begin
               wtgt_q <= VIO_WT_VEC;
               vsel_q <= ~port_wdata[2:0];  // slot code is the inverted level
            end
         end
      end
   end

   // vector memory; contents hold no reset meaning
   // leaving it out of the reset tree saves area, at the price that an
   // unwritten slot answers an acknowledge with unknown data
   always_ff @(posedge sys_clk) begin
      if (dat_wr && wtgt_q == VIO_WT_VEC) begin
         vec_q[vsel_q] <= port_wdata;
      end
   end

   // ==========================================================================
   // status and read port
   logic [7:0] status;  // controller_state_reg
   // the pending code is only meaningful while the top flag is set; the
   // polarity options are never shown because they always read zero
   always_comb begin
      status            = ZERO8;
      status[2:0]       = ~win;
      status[ST_ARMED]  = opt_q[OPT_ARM];
      status[ST_POLL]   = opt_q[OPT_POLL];
      status[ST_ROTATE] = opt_q[OPT_ROTATE];
      status[ST_GROUP]  = any_live;
   end

   // registered answer one cycle after the strobe or acknowledge
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         port_rdata  <= ZERO8;
         port_rvalid <= 1'b0;
      end else begin
         port_rvalid <= port_rd || ack;
         // an acknowledge outranks a read in the same cycle
         if (ack) begin
            // common mode always answers with the level seven slot
            port_rdata <= opt_q[OPT_COMMON] ? vec_q[7] : vec_q[win];
         end else if (port_rd && port_ctrl) begin
            port_rdata <= status;
         end else if (port_rd) begin
            // data reads follow the preselect bits; writes never consult them
            case (opt_q[OPT_RSEL_HI:OPT_RSEL_LO])
               RSEL_REQ:  port_rdata <= req_q;
               RSEL_SVC:  port_rdata <= svc_q;
               RSEL_MASK: port_rdata <= mask_q;
               RSEL_ACLR: port_rdata <= aclr_q;
               default:   port_rdata <= ZERO8;
            endcase
         end
      end
   end

   // group interrupt; registered, inactive high during reset
   // the register adds one cycle of lag, traded for a glitch-free pin
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         group_int_n <= 1'b1;
      end else begin
         group_int_n <= !(any_live && allow && !opt_q[OPT_POLL]);
      end
   end
endmodule
`default_nettype wire

// File: vio_pkg.sv
package vio_pkg;
   // ==========================================================================
   // option register field positions
   localparam int OPT_ROTATE   = 0;   // priority_rotate_select
   localparam int OPT_COMMON   = 1;   // common_vector_select
   localparam int OPT_POLL     = 2;   // poll_select
   localparam int OPT_OUTPOL   = 3;   // output_polarity_bit, held zero
   localparam int OPT_REQPOL   = 4;   // request_polarity_bit, held zero
   localparam int OPT_RSEL_LO  = 5;   // read_select_low
   localparam int OPT_RSEL_HI  = 6;   // read_select_high
   localparam int OPT_ARM      = 7;   // arm_bit
   localparam logic [7:0] OPT_RESET = 8'h20;  // in-service preselected, disarmed
   // ==========================================================================
   // status register field positions
   localparam int ST_ARMED     = 3;
   localparam int ST_POLL      = 4;
   localparam int ST_ROTATE    = 5;
   localparam int ST_GROUP     = 7;
   // ==========================================================================
   // data-port read selection
   localparam logic [1:0] RSEL_REQ  = 2'h0;
   localparam logic [1:0] RSEL_SVC  = 2'h1;
   localparam logic [1:0] RSEL_MASK = 2'h2;
   localparam logic [1:0] RSEL_ACLR = 2'h3;
   // ==========================================================================
   // data-port write targets, chosen by commands
   typedef enum logic [1:0] {
      VIO_WT_MASK = 2'b00,
      VIO_WT_ACLR = 2'b01,
      VIO_WT_VEC  = 2'b10
   } vio_wtgt_t;
   // register reset values
   localparam logic [7:0] MASK_RESET = 8'hFF;
   localparam logic [7:0] ZERO8      = 8'h00;
   // request filter: low samples counted before the next low sample is accepted as a request
   localparam int FILTER_CYCLES = 2;
endpackage

// File: vio_req_filter.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// spike filter for one active-low request line; emits a one-cycle catch pulse
module vio_req_filter
   import vio_pkg::*;
#(
   parameter int HOLD = FILTER_CYCLES  // low samples seen before the accepted one
) (
   input  wire logic sys_clk,
   input  wire logic resetn,
   input  wire logic req_n,
   output logic      caught
);
   logic [3:0] run_q;   // consecutive low samples seen
   logic       done_q;  // request already reported for this low stretch

   // count the low stretch; a narrow glitch resets before reaching HOLD
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         run_q  <= 4'h0;
         done_q <= 1'b0;
      end else if (req_n) begin
         run_q  <= 4'h0;
         done_q <= 1'b0;
      end else if (run_q < 4'(HOLD)) begin
         run_q  <= run_q + 4'h1;
      end else begin
         done_q <= 1'b1;
      end
   end

   // pulse once per accepted low stretch, so one-shot and held lines both latch
   assign caught = !req_n && (run_q >= 4'(HOLD)) && !done_q;
endmodule
`default_nettype wire

// File: vio_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// port checker: status fields, answers, poll and reset behaviour
module vio_ctrl_chk (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       port_rd,
   input  wire logic       port_wr,
   input  wire logic       port_ctrl,
   input  wire logic [7:0] port_wdata,
   input  wire logic       inta,
   input  wire logic [7:0] port_rdata,
   input  wire logic       port_rvalid,
   input  wire logic       group_int_n
);
   logic arm_q;  // arm state seen through commands
   logic pol_q;  // poll option
   logic rot_q;  // rotation option
   // shadow of the option bits; only commands move them, never data writes
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         {arm_q, pol_q, rot_q} <= 3'h0;
      end else if (port_wr && port_ctrl && port_wdata == 8'h00) begin
         {arm_q, pol_q, rot_q} <= 3'h0;
      end else if (port_wr && port_ctrl && port_wdata[7:5] == 3'h4) begin
         {pol_q, rot_q} <= {port_wdata[2], port_wdata[0]};
      end else if (port_wr && port_ctrl && port_wdata[7:4] == 4'hA) begin
         // arm field 01 sets, 10 clears, others leave it
         if (port_wdata[1:0] == 2'h1) arm_q <= 1'b1;
         else if (port_wdata[1:0] == 2'h2) arm_q <= 1'b0;
      end
   end
   // ==========================================================================
   // assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence ctrl_rd_s;
      port_rd && port_ctrl && !port_wr && !inta;
   endsequence
   sequence zero_cmd_s;
      port_wr && port_ctrl && port_wdata == 8'h00 ##1 !port_wr;
   endsequence
   AST_CTRL_READ: assert property (ctrl_rd_s |=> port_rvalid)
      else $error("control read got no answer");
   AST_ARM_FLAG: assert property (ctrl_rd_s |=> port_rdata[3] == arm_q)
      else $error("armed flag differs from arm state");
   AST_MODE_FLAGS: assert property (ctrl_rd_s |=> port_rdata[6:4] == {1'b0, rot_q, pol_q})
      else $error("mode flags differ from options");
   AST_DISARM_IDLE: assert property (ctrl_rd_s ##1 !port_rdata[3] |-> !port_rdata[7])
      else $error("pending flag set while disarmed");
   AST_WRITE_SILENT: assert property (port_wr && !port_rd && !inta |=> !port_rvalid)
      else $error("write produced an answer");
   AST_ANSWER_CAUSE: assert property (port_rvalid |-> $past(port_rd || inta))
      else $error("answer without request");
   AST_POLL_QUIET: assert property (pol_q && $past(pol_q) |-> group_int_n)
      else $error("group interrupt in poll mode");
   AST_POLL_NO_ACK: assert property (pol_q && inta && !port_rd |=> !port_rvalid)
      else $error("acknowledge answered in poll mode");
   AST_RESET_CMD: assert property (zero_cmd_s |=> group_int_n)
      else $error("group interrupt after zero command");
   AST_ACK_ANSWER: assert property (inta && !port_rd && !pol_q && !group_int_n &&
      !$past(inta) && !$past(port_wr) |=> port_rvalid)
      else $error("raised interrupt not acknowledged");
endmodule
bind vio_ctrl vio_ctrl_chk vio_ctrl_chk_inst (.sys_clk(sys_clk), .resetn(resetn),
   .port_rd(port_rd), .port_wr(port_wr), .port_ctrl(port_ctrl), .port_wdata(port_wdata),
   .inta(inta), .port_rdata(port_rdata), .port_rvalid(port_rvalid),
   .group_int_n(group_int_n));
`default_nettype wire

// File: vio_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// host processor: one-cycle strobes launched on falling edges
module vio_host_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] port_rdata,
   input  wire logic       port_rvalid,
   output logic            port_rd,
   output logic            port_wr,
   output logic            port_ctrl,
   output logic [7:0]      port_wdata,
   output logic            inta
);
   initial begin
      {port_rd, port_wr, port_ctrl, inta} = 4'h0;
      port_wdata = 8'h00;
   end
   // one transfer; the answer is awaited for at most three cycles
   task automatic pulse(input logic r, w, a, c, input logic [7:0] d,
                        output logic ok, output logic [7:0] q);
      @(negedge sys_clk);
      {port_rd, port_wr, inta, port_ctrl} = {r, w, a, c};
      port_wdata = d;
      @(negedge sys_clk);
      {port_rd, port_wr, inta} = 3'h0;
      port_wdata = ~d;  // released bus never shows stale data
      ok = 1'b0;
      q = 8'h00;
      // the answer stands for one cycle only, so look before the next edge
      for (int i = 0; i < 3 && !ok; i++) begin
         ok = (port_rvalid === 1'b1);
         q = port_rdata;
         if (!ok) @(negedge sys_clk);
      end
   endtask
endmodule
`default_nettype wire

// File: vio_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vio_ctrl_tb_top;
   logic       sys_clk = 1'b0;
   logic       resetn = 1'b0;
   logic [7:0] bus_req_n = 8'hFF;
   logic [7:0] port_rdata, port_wdata, q;
   logic       port_rd, port_wr, port_ctrl, inta, port_rvalid, group_int_n, ok;
   bit   [7:0] req, svc, acl, msk, vec[8];  // reference model state
   bit         rot, com, pol, arm;
   int         sel, lsv, wt, vl, w, errors, tests_run;
   bit  [31:0] seed = 32'h15;
   always #12.5 sys_clk = ~sys_clk;
   vio_ctrl #(.LEVELS(8)) vio_ctrl_inst (.sys_clk(sys_clk), .resetn(resetn),
      .bus_req_n(bus_req_n), .port_rd(port_rd), .port_wr(port_wr), .port_ctrl(port_ctrl),
      .port_wdata(port_wdata), .inta(inta), .port_rdata(port_rdata),
      .port_rvalid(port_rvalid), .group_int_n(group_int_n));
   vio_host_model vio_host_model_inst (.sys_clk(sys_clk), .port_rdata(port_rdata),
      .port_rvalid(port_rvalid), .port_rd(port_rd), .port_wr(port_wr),
      .port_ctrl(port_ctrl), .port_wdata(port_wdata), .inta(inta));
   function automatic bit [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic test_done();
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ==========================================================================
   // reference model
   task automatic mreset();
      {req, svc, acl, msk} = 32'hFF;
      {rot, com, pol, arm} = 4'h0;
      sel = 1;  // rotation anchor and write target survive the zero command
   endtask
   // rotation searches downward from the level below the last one served
   function automatic int winner();
      bit [7:0] c = arm ? (req & ~msk) : 8'h00;
      for (int i = 1; i <= 8; i++) begin
         int l = rot ? (lsv + 8 - i) % 8 : 8 - i;
         if (c[l]) return l;
      end
      return -1;
   endfunction
   function automatic bit [7:0] dsel();
      return sel == 0 ? req : sel == 1 ? svc : sel == 2 ? msk : acl;
   endfunction
   task automatic cmd(input bit [7:0] c);
      vio_host_model_inst.pulse(1'b0, 1'b1, 1'b0, 1'b1, c, ok, q);
      casez (c)
         8'h00: mreset();
         8'b0010_0???: msk = 8'h00;
         8'b0111_0???: svc = 8'h00;
         8'b100?_????: {pol, com, rot} = c[2:0];
         8'b1010_????: begin
            sel = c[3:2];
            arm = c[1:0] == 2'h1 ? 1'b1 : c[1:0] == 2'h2 ? 1'b0 : arm;
         end
         8'b1011_????: wt = 0;
         8'b1100_????: wt = 1;
         8'b1110_0???: {wt, vl} = {32'd2, 32'(7 - c[2:0])};
         default: ;
      endcase
   endtask
   task automatic dwr(input bit [7:0] d);
      vio_host_model_inst.pulse(1'b0, 1'b1, 1'b0, 1'b0, d, ok, q);
      if (wt == 0) msk = d;
      else if (wt == 1) acl = d;
      else vec[vl] = d;
   endtask
   task automatic rd(input logic c, input bit [7:0] e, m);
      vio_host_model_inst.pulse(1'b1, 1'b0, 1'b0, c, 8'h00, ok, q);
      chk(ok, 8'h01);
      chk(q & m, e & m);
      if (ok !== 1'b1) test_done();
   endtask
   // requests held n cycles; up to two low samples are noise
   task automatic raise(input bit [7:0] l, input int n);
      @(negedge sys_clk);
      bus_req_n = ~l;
      repeat (n) @(negedge sys_clk);
      bus_req_n = 8'hFF;
      if (n > 2) req = req | l;
      repeat (3) @(negedge sys_clk);
   endtask
   // one service round: status, acknowledge, then the selected data register
   task automatic step();
      bit pe;
      w = winner();
      pe = w >= 0 && !pol && (rot ? svc == 0 : (svc >> w) == 0);
      chk(group_int_n, !pe);
      rd(1'b1, {w >= 0, 1'b0, rot, pol, arm, 3'(~w)}, w >= 0 ? 8'hFF : 8'hF8);
      vio_host_model_inst.pulse(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, ok, q);
      chk(ok, pe);
      if (pe) begin
         chk(q, vec[com ? 7 : w]);
         req[w] = 1'b0;
         svc[w] = !acl[w];
         lsv = w;
      end else cmd(8'h70);
      rd(1'b0, dsel(), 8'hFF);
   endtask
   task automatic serve(input bit [7:0] md, a, l);
      cmd(8'h00);
      for (int i = 0; i < 8; i++) begin
         cmd(8'hE0 | 8'(7 - i));
         dwr(8'(rnd()));
      end
      cmd(8'hB0);
      dwr(8'(rnd()) & 8'h11);
      cmd(8'hC0);
      dwr(a);
      cmd(8'h80 | md);
      cmd(8'hA5);
      raise(l, 4);
      repeat (9) step();
   endtask
   initial begin
      mreset();
      repeat (6) @(negedge sys_clk);
      resetn = 1'b1;
      step();
      cmd(8'h20);
      cmd(8'hA5);
      raise(8'h08, 1);
      step();
      for (int i = 0; i < 8; i++) serve(8'(i) | 8'h18, 8'(rnd()), 8'(rnd()) | 8'h01);
      serve(8'h00, 8'h00, 8'hFF);
      serve(8'h01, 8'hFF, 8'hFF);
      cmd(8'hA2);
      raise(8'h81, 4);
      step();
      cmd(8'hA9);
      step();
      cmd(8'h00);
      cmd(8'hAC);
      cmd(8'hB0);
      dwr(8'h5A);
      step();
      cmd(8'hA8);
      step();
      test_done();
   end
endmodule
`default_nettype wire
